// >>> core/can_accept_pkg.sv
// Constants shared by the identifier acceptance filter and its register port.
// Assumes byte-wide registers on a plain strobe port and a destuffed bit feed.
package can_accept_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int N_BYTES = 8;
  // Register offsets
  localparam logic [4:0] OFS_CODE_BASE = 5'h00;
  localparam logic [4:0] OFS_MASK_BASE = 5'h08;
  localparam logic [4:0] OFS_CTRL = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h11;
  // Control field positions and reset values
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_EN_LSB = 4;
  localparam logic [7:0] CTRL_RST = 8'hF0;
  localparam logic [7:0] CODE_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'hFF;
  // Status field positions
  localparam int STAT_ACC_BIT = 0;
  localparam int STAT_REJ_BIT = 1;
  localparam int STAT_HIT_LSB = 2;
  localparam int STAT_EXT_BIT = 4;
  localparam int STAT_BUSY_BIT = 5;
  // Arbitration word layout, first received bit at bit 31
  localparam logic [4:0] ID_MSB = 5'h1F;
  localparam int IDE_POS = 19;
  localparam logic [5:0] CNT_IDE = 6'h0C;
  localparam logic [5:0] CNT_LAST = 6'h1F;
  localparam logic [31:0] STD_CARE = 32'hFFF80000;
  localparam logic [31:0] EXT_CARE = 32'hFFFFFFFF;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_COLLECT = 2'b01,
    ST_DONE = 2'b10
  } frame_state_t;
endpackage

// >>> core/id_filter_match.sv
// One acceptance filter: code compare under mask and a care vector.
// Assumes all inputs are stable within the cycle; purely combinational.
`timescale 1ns/1ps
module id_filter_match #(
  parameter int W = 32
) (
  input wire logic [W-1:0] i_id,
  input wire logic [W-1:0] i_code,
  input wire logic [W-1:0] i_mask,
  input wire logic [W-1:0] i_care,
  output logic o_hit
);
  // A set mask bit or a bit outside the identifier never blocks a hit
  assign o_hit = &(~(i_id ^ i_code) | i_mask | ~i_care);
endmodule

// >>> core/can_id_accept.sv
// Identifier acceptance filter of a CAN receiver with its register port.
// Assumes the bit-stream logic on i_clk delivers each received bit with a
// strobe and flags stuff bits; a start-of-frame pulse precedes the identifier.
// Functional notes
// - Two software-selected modes: two 32-bit filters or four 16-bit filters.
// - Extended frames assemble all 29 identifier bits before being filtered.
// - Second filter byte is compared only once identifier bit 15 is in.
// - Byte 1 checks codes 1 and 5; 16-bit mode also codes 3 and 7.
// - Mask bit one is don't-care; second mask byte maps ID20-18, SRR, IDE, ID17-15.
// - Stuff bit between ID16 and ID15 never causes a wrong rejection.
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module can_id_accept (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  output logic [7:0] o_rd_data,
  input wire logic i_sof,
  input wire logic i_bit_valid,
  input wire logic i_bit,
  input wire logic i_bit_stuff,
  output logic o_accept,
  output logic o_reject,
  output logic [1:0] o_hit_index,
  output logic [31:0] o_id_word,
  output logic o_ext_frame
);
  logic [7:0] code_reg [can_accept_pkg::N_BYTES];
  logic [7:0] mask_reg [can_accept_pkg::N_BYTES];
  logic [7:0] ctrl_reg;
  logic [31:0] id_reg;
  logic [5:0] cnt_reg;
  logic done_reg;
  logic acc_last_reg;
  logic rej_last_reg;
  can_accept_pkg::frame_state_t state_reg;
  logic take_bit;
  logic mode16;
  logic [3:0] filt_en;
  logic [31:0] care;
  logic [1:0] hit32;
  logic [3:0] hit16;
  logic sel_any;
  logic [1:0] sel_idx;
  logic [7:0] rd_next;

  assign mode16 = ctrl_reg[can_accept_pkg::CTRL_MODE_BIT];
  assign filt_en = ctrl_reg[can_accept_pkg::CTRL_EN_LSB +: 4];
  // Stuff bits are dropped here so they never move the shift position
  assign take_bit = i_bit_valid & ~i_bit_stuff & ~i_sof;
  // Standard frames carry only 13 identifier-side bits; the rest is ignored
  assign care = id_reg[can_accept_pkg::IDE_POS] ? can_accept_pkg::EXT_CARE : can_accept_pkg::STD_CARE;

  // Register writes; status is read-only and writes to it are dropped
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      for (int i = 0; i < can_accept_pkg::N_BYTES; i++) begin
        code_reg[i] <= can_accept_pkg::CODE_RST;
        mask_reg[i] <= can_accept_pkg::MASK_RST;
      end
      ctrl_reg <= can_accept_pkg::CTRL_RST;
    end else if (i_wr_stb) begin
      if (i_addr[4:3] == can_accept_pkg::OFS_CODE_BASE[4:3]) begin
        code_reg[i_addr[2:0]] <= i_wr_data;
      end else if (i_addr[4:3] == can_accept_pkg::OFS_MASK_BASE[4:3]) begin
        mask_reg[i_addr[2:0]] <= i_wr_data;
      end else if (i_addr == can_accept_pkg::OFS_CTRL) begin
        ctrl_reg <= i_wr_data;
      end
    end
  end

  // Identifier assembly, MSB first, one position per destuffed bit
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_reg <= can_accept_pkg::ST_IDLE;
      id_reg <= 32'h00000000;
      cnt_reg <= 6'h00;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (i_sof) begin
        state_reg <= can_accept_pkg::ST_COLLECT;
        id_reg <= 32'h00000000;
        cnt_reg <= 6'h00;
      end else if (state_reg == can_accept_pkg::ST_COLLECT && take_bit) begin
        id_reg[can_accept_pkg::ID_MSB - cnt_reg[4:0]] <= i_bit;
        cnt_reg <= cnt_reg + 6'h01;
        // Extended frames wait for all 32 bits, so ID15 is in before compare
        if ((cnt_reg == can_accept_pkg::CNT_IDE && !i_bit) || cnt_reg == can_accept_pkg::CNT_LAST) begin
          state_reg <= can_accept_pkg::ST_DONE;
          done_reg <= 1'b1;
        end
      end
    end
  end

  // 32-bit filters use bytes 4f..4f+3, byte 1 of each being code 1 or 5
  for (genvar f = 0; f < 2; f++) begin : g_f32
    id_filter_match #(.W(32)) u_match (
      .i_id(id_reg),
      .i_code({code_reg[4*f], code_reg[4*f+1], code_reg[4*f+2], code_reg[4*f+3]}),
      .i_mask({mask_reg[4*f], mask_reg[4*f+1], mask_reg[4*f+2], mask_reg[4*f+3]}),
      .i_care(care),
      .o_hit(hit32[f])
    );
  end

  // 16-bit filters use byte pairs; second byte of each is code 1, 3, 5 or 7
  for (genvar g = 0; g < 4; g++) begin : g_f16
    id_filter_match #(.W(16)) u_match (
      .i_id(id_reg[31:16]),
      .i_code({code_reg[2*g], code_reg[2*g+1]}),
      .i_mask({mask_reg[2*g], mask_reg[2*g+1]}),
      .i_care(care[31:16]),
      .o_hit(hit16[g])
    );
  end

  // Mode select and lowest-numbered enabled hit
  always_comb begin
    sel_any = 1'b0;
    sel_idx = 2'h0;
    if (mode16) begin
      sel_any = |(hit16 & filt_en);
      for (int k = 3; k >= 0; k--) begin
        if (hit16[k] && filt_en[k]) begin
          sel_idx = 2'(k);
        end
      end
    end else begin
      sel_any = |(hit32 & filt_en[1:0]);
      sel_idx = (hit32[0] && filt_en[0]) ? 2'h0 : 2'h1;
    end
  end

  // Decision pulses; rejection only drops the frame, acknowledge stays upstream
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_accept <= 1'b0;
      o_reject <= 1'b0;
      o_hit_index <= 2'h0;
      o_id_word <= 32'h00000000;
      o_ext_frame <= 1'b0;
      acc_last_reg <= 1'b0;
      rej_last_reg <= 1'b0;
    end else begin
      o_accept <= done_reg & sel_any;
      o_reject <= done_reg & ~sel_any;
      if (done_reg) begin
        o_hit_index <= sel_any ? sel_idx : 2'h0;
        o_id_word <= id_reg;
        o_ext_frame <= id_reg[can_accept_pkg::IDE_POS];
        acc_last_reg <= sel_any;
        rej_last_reg <= ~sel_any;
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_next = 8'h00;
    if (i_addr[4:3] == can_accept_pkg::OFS_CODE_BASE[4:3]) begin
      rd_next = code_reg[i_addr[2:0]];
    end else if (i_addr[4:3] == can_accept_pkg::OFS_MASK_BASE[4:3]) begin
      rd_next = mask_reg[i_addr[2:0]];
    end else if (i_addr == can_accept_pkg::OFS_CTRL) begin
      rd_next = ctrl_reg;
    end else if (i_addr == can_accept_pkg::OFS_STATUS) begin
      rd_next[can_accept_pkg::STAT_ACC_BIT] = acc_last_reg;
      rd_next[can_accept_pkg::STAT_REJ_BIT] = rej_last_reg;
      rd_next[can_accept_pkg::STAT_HIT_LSB +: 2] = o_hit_index;
      rd_next[can_accept_pkg::STAT_EXT_BIT] = o_ext_frame;
      rd_next[can_accept_pkg::STAT_BUSY_BIT] = (state_reg == can_accept_pkg::ST_COLLECT);
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rd_data <= 8'h00;
    end else begin
      o_rd_data <= i_rd_stb ? rd_next : 8'h00;
    end
  end

  // Helpers for the assertions below
  logic byte1_miss0;
  logic byte1_miss5;
  logic byte3_miss;
  logic sel_enabled;
  assign byte1_miss0 = |((id_reg[23:16] ^ code_reg[1]) & ~mask_reg[1] & care[23:16]);
  assign byte1_miss5 = |((id_reg[23:16] ^ code_reg[5]) & ~mask_reg[5] & care[23:16]);
  // Byte 3 is the second byte of 16-bit filter 1
  assign byte3_miss = |((id_reg[23:16] ^ code_reg[3]) & ~mask_reg[3] & care[23:16]);
  // Enable bit behind the reported index; a disabled filter must never win
  assign sel_enabled = filt_en[sel_idx];

  // Verdict follows the mode that stands when the identifier completes
  AST_MODE_SELECT: assert property (@(posedge i_clk) disable iff (i_srst)
    done_reg |=> o_accept == $past(mode16 ? |(hit16 & filt_en) : |(hit32 & filt_en[1:0])))
    else $error("accept does not follow selected mode");

  // An extended identifier is filtered only once all 32 positions are in
  AST_EXT_FULL_ID: assert property (@(posedge i_clk) disable iff (i_srst)
    done_reg && id_reg[can_accept_pkg::IDE_POS] |-> cnt_reg == 6'h20)
    else $error("extended frame filtered before full identifier");

  // A flagged stuff bit leaves position and contents alone
  AST_STUFF_NO_SHIFT: assert property (@(posedge i_clk) disable iff (i_srst)
    i_bit_valid && i_bit_stuff && !i_sof |=> $stable(id_reg) && $stable(cnt_reg))
    else $error("stuff bit moved the identifier");

  // Byte 1 mismatching both codes 1 and 5 blocks a 32-bit accept
  AST_BYTE1_CHECK: assert property (@(posedge i_clk) disable iff (i_srst)
    done_reg && !mode16 && byte1_miss0 && byte1_miss5 |=> !o_accept)
    else $error("byte 1 mismatch accepted in 32-bit mode");

  // A fully masked filter 0, enabled in 32-bit mode, takes every frame at index 0
  AST_MASK_OPEN: assert property (@(posedge i_clk) disable iff (i_srst)
    done_reg && !mode16 && filt_en[0] && mask_reg[0] == 8'hFF && mask_reg[1] == 8'hFF &&
    mask_reg[2] == 8'hFF && mask_reg[3] == 8'hFF |=> o_accept && o_hit_index == 2'h0)
    else $error("fully masked filter did not accept");

  // The count moves only for data bits; the clear after start of frame is exempt
  AST_SHIFT_CAUSE: assert property (@(posedge i_clk) disable iff (i_srst)
    !$past(i_sof) && cnt_reg != $past(cnt_reg) |-> $past(take_bit) && cnt_reg == $past(cnt_reg) + 6'h01)
    else $error("identifier advanced without a data bit");

  // Exactly one verdict pulse per finished identifier
  AST_ONE_VERDICT: assert property (@(posedge i_clk) disable iff (i_srst)
    done_reg |=> (o_accept ^ o_reject) ##1 (!o_accept && !o_reject))
    else $error("frame verdict not exactly one pulse");

  // No verdict appears without a finished identifier
  AST_NO_SPURIOUS: assert property (@(posedge i_clk) disable iff (i_srst)
    !done_reg |=> !o_accept && !o_reject)
    else $error("verdict without a finished identifier");

  // A standard frame completes right after its identifier-extension bit
  AST_STD_EARLY_DONE: assert property (@(posedge i_clk) disable iff (i_srst)
    done_reg && !id_reg[can_accept_pkg::IDE_POS] |-> cnt_reg == 6'h0D)
    else $error("standard frame finished at the wrong bit");

  // The reported word and format are those of the frame just judged
  AST_ID_WORD_KEPT: assert property (@(posedge i_clk) disable iff (i_srst)
    done_reg |=> o_id_word == $past(id_reg) && o_ext_frame == $past(id_reg[can_accept_pkg::IDE_POS]))
    else $error("reported identifier differs from assembled one");

  // Bits arriving outside the identifier never touch the assembly
  AST_NO_BITS_AFTER_ID: assert property (@(posedge i_clk) disable iff (i_srst)
    state_reg != can_accept_pkg::ST_COLLECT && !i_sof |=> $stable(id_reg) && $stable(cnt_reg))
    else $error("identifier changed outside collection");

  // In 16-bit mode byte 3 guards filter 1 like byte 1 guards filter 0
  AST_MODE16_BYTE3: assert property (@(posedge i_clk) disable iff (i_srst)
    done_reg && mode16 && byte3_miss |-> !hit16[1])
    else $error("byte 3 mismatch hit 16-bit filter 1");

  // A written mask byte holds the written value
  AST_MASK_WRITE: assert property (@(posedge i_clk) disable iff (i_srst)
    i_wr_stb && i_addr[4:3] == can_accept_pkg::OFS_MASK_BASE[4:3] |=> mask_reg[$past(i_addr[2:0])] == $past(i_wr_data))
    else $error("mask byte write lost");

  // Mode and enables take the written control value
  AST_CTRL_WRITE: assert property (@(posedge i_clk) disable iff (i_srst)
    i_wr_stb && i_addr == can_accept_pkg::OFS_CTRL |=> ctrl_reg == $past(i_wr_data))
    else $error("control write lost");

  // Read data are zero in every cycle not following a read strobe
  AST_RD_IDLE_ZERO: assert property (@(posedge i_clk) disable iff (i_srst)
    !i_rd_stb |=> o_rd_data == 8'h00)
    else $error("read data outside the answer cycle");

  // Only an enabled filter may be named as the winner
  AST_HIT_ENABLED: assert property (@(posedge i_clk) disable iff (i_srst)
    done_reg && sel_any |-> sel_enabled)
    else $error("disabled filter selected");

  // A rejected frame reports index zero
  AST_REJECT_INDEX: assert property (@(posedge i_clk) disable iff (i_srst)
    o_reject |-> o_hit_index == 2'h0)
    else $error("reject carries a filter index");

  // Status flags follow the verdict pulse
  AST_LAST_FLAGS: assert property (@(posedge i_clk) disable iff (i_srst)
    done_reg |=> acc_last_reg == o_accept && rej_last_reg == o_reject)
    else $error("status flags disagree with verdict");

  // Busy status mirrors collection at the read strobe
  AST_BUSY_STATUS: assert property (@(posedge i_clk) disable iff (i_srst)
    i_rd_stb && i_addr == can_accept_pkg::OFS_STATUS |=>
    o_rd_data[can_accept_pkg::STAT_BUSY_BIT] == $past(state_reg == can_accept_pkg::ST_COLLECT))
    else $error("busy status wrong");

  // Main scenarios worth seeing at least once
  COV_EXT_ACCEPT: cover property (@(posedge i_clk) disable iff (i_srst) o_accept && o_ext_frame);
  COV_STD_REJECT: cover property (@(posedge i_clk) disable iff (i_srst) o_reject && !o_ext_frame);
  COV_MODE16_HIT3: cover property (@(posedge i_clk) disable iff (i_srst) o_accept && o_hit_index == 2'h3);
  COV_STUFF_AT_ID15: cover property (@(posedge i_clk) disable iff (i_srst)
    state_reg == can_accept_pkg::ST_COLLECT && i_bit_valid && i_bit_stuff && cnt_reg == 6'h0F);
  COV_STD_ACCEPT: cover property (@(posedge i_clk) disable iff (i_srst) o_accept && !o_ext_frame);
endmodule

// >>> verif/can_node_model.sv
// Remote CAN node: feeds destuffed bits with stuff flags.
// Assumes a one-cycle i_go pulse while idle.
`timescale 1ns/1ps
module can_node_model (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [31:0] i_word,
  input wire logic [5:0] i_nbits,
  input wire logic [5:0] i_stuff_at,
  input wire logic i_slow,
  output logic o_sof = 1'b0,
  output logic o_bit_valid = 1'b0,
  output logic o_bit = 1'b0,
  output logic o_bit_stuff = 1'b0,
  output logic o_last = 1'b0
);
  int n;
  // Idle data toggles so a stale bit never looks valid
  always begin
    @(posedge i_clk);
    o_bit <= ~o_bit;
    if (i_go) begin
      o_sof <= 1'b1;
      @(posedge i_clk);
      o_sof <= 1'b0;
      for (n = 0; n < i_nbits; n++) begin
        if (n == i_stuff_at) begin // Opposite-level stuff bit
          o_bit_valid <= 1'b1;
          o_bit_stuff <= 1'b1;
          o_bit <= ~o_bit;
          @(posedge i_clk);
        end
        o_bit_valid <= 1'b1;
        o_bit_stuff <= 1'b0;
        o_bit <= i_word[31-n];
        o_last <= (n == i_nbits - 1);
        @(posedge i_clk);
        if (i_slow) begin // Slow node leaves gaps
          o_bit_valid <= 1'b0;
          o_bit <= ~o_bit;
          @(posedge i_clk);
        end
      end
      o_bit_valid <= 1'b0;
      o_last <= 1'b0;
    end
  end
endmodule

// >>> verif/tb_can_identifier_acceptance_filter.sv
// Self-checking bench for the identifier acceptance filter.
// Assumes the node model drives the bit feed; the bench owns the register port.
`timescale 1ns/1ps
module tb_can_identifier_acceptance_filter;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [4:0] i_addr = 5'h00;
  logic [7:0] i_wr_data = 8'h00;
  logic i_wr_stb = 1'b0;
  logic i_rd_stb = 1'b0;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic [31:0] word = 32'h0;
  logic [5:0] nbits = 6'h00;
  logic [5:0] stuff_at = 6'h3F;
  logic sof, bit_valid, rx_bit, bit_stuff, last, o_accept, o_reject, o_ext_frame;
  logic [7:0] o_rd_data;
  logic [1:0] o_hit_index;
  logic [31:0] o_id_word;
  int n_errors = 0;
  int checks_done = 0;
  localparam logic [31:0] W_EXT = 32'hA5B83C5A;
  always #25 i_clk = ~i_clk;
  can_node_model u_node (.i_clk(i_clk), .i_go(go), .i_word(word), .i_nbits(nbits), .i_stuff_at(stuff_at),
    .i_slow(slow), .o_sof(sof), .o_bit_valid(bit_valid), .o_bit(rx_bit), .o_bit_stuff(bit_stuff), .o_last(last));
  can_id_accept u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data), .i_sof(sof), .i_bit_valid(bit_valid),
    .i_bit(rx_bit), .i_bit_stuff(bit_stuff), .o_accept(o_accept), .o_reject(o_reject),
    .o_hit_index(o_hit_index), .o_id_word(o_id_word), .o_ext_frame(o_ext_frame));
  // Shared comparison and closing report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Register port cycles; strobes last one cycle
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr_stb <= 1'b1;
    @(posedge i_clk);
    i_wr_stb <= 1'b0;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd_stb <= 1'b1;
    @(posedge i_clk);
    i_rd_stb <= 1'b0;
    #1;
    check(o_rd_data, e);
  endtask
  task automatic set4(input logic [4:0] base, input logic [31:0] w);
    for (int i = 0; i < 4; i++) begin
      wr(base + 5'(i), w[31-8*i -: 8]);
    end
  endtask
  // One frame; verdict lands two cycles after the final bit, for one cycle
  task automatic frame(input logic [31:0] w, input logic [5:0] nb, input logic [5:0] st, input logic sl,
    input logic acc, input logic [1:0] hit);
    int k;
    k = 0;
    @(posedge i_clk);
    go <= 1'b1;
    word <= w;
    nbits <= nb;
    stuff_at <= st;
    slow <= sl;
    @(posedge i_clk);
    go <= 1'b0;
    while (last !== 1'b1 && k < 200) begin
      @(negedge i_clk);
      k++;
    end
    if (k >= 200) begin
      n_errors++;
      give_verdict();
    end
    repeat (2) @(posedge i_clk);
    #1;
    check({o_accept, o_reject, o_hit_index}, {acc, ~acc, hit});
    @(posedge i_clk);
    #1;
    check({o_accept, o_reject}, 2'h0);
  endtask
  task automatic t_reset();
    rd_chk(can_accept_pkg::OFS_CTRL, can_accept_pkg::CTRL_RST);
    rd_chk(can_accept_pkg::OFS_MASK_BASE + 5'h07, can_accept_pkg::MASK_RST);
    @(posedge i_clk);
    #1;
    check(o_rd_data, 8'h00);
    rd_chk(can_accept_pkg::OFS_CODE_BASE, can_accept_pkg::CODE_RST);
    wr(can_accept_pkg::OFS_STATUS, 8'hFF);
    rd_chk(can_accept_pkg::OFS_STATUS, 8'h00);
    rd_chk(5'h1F, 8'h00);
    $display("test reset done");
  endtask
  // Stuff bit between ID16 and ID15 must not shift the second byte
  task automatic t_ext_stuff();
    set4(can_accept_pkg::OFS_CODE_BASE, W_EXT);
    set4(can_accept_pkg::OFS_MASK_BASE, 32'h0);
    wr(can_accept_pkg::OFS_CTRL, 8'h10);
    frame(W_EXT, 6'h20, 6'h0F, 1'b0, 1'b1, 2'h0);
    check(o_id_word, W_EXT);
    check(o_ext_frame, 1'b1);
    rd_chk(can_accept_pkg::OFS_STATUS, 8'h11);
    $display("test ext_stuff done");
  endtask
  task automatic t_mask();
    wr(can_accept_pkg::OFS_CODE_BASE + 5'h01, 8'hB9);
    wr(can_accept_pkg::OFS_MASK_BASE + 5'h05, 8'h00);
    frame(W_EXT, 6'h20, 6'h0F, 1'b1, 1'b0, 2'h0);
    rd_chk(can_accept_pkg::OFS_STATUS, 8'h12);
    wr(can_accept_pkg::OFS_MASK_BASE + 5'h01, 8'h01);
    frame(W_EXT, 6'h20, 6'h0F, 1'b0, 1'b1, 2'h0);
    $display("test mask done");
  endtask
  // Filter 0 misses; filter 1 decides on its second byte
  task automatic t_mode16();
    wr(can_accept_pkg::OFS_CTRL, 8'h31);
    wr(can_accept_pkg::OFS_CODE_BASE, 8'h00);
    wr(can_accept_pkg::OFS_CODE_BASE + 5'h02, 8'hA5);
    wr(can_accept_pkg::OFS_CODE_BASE + 5'h03, 8'hB9);
    frame(W_EXT, 6'h20, 6'h0F, 1'b0, 1'b0, 2'h0);
    wr(can_accept_pkg::OFS_CODE_BASE + 5'h03, 8'hB8);
    frame(W_EXT, 6'h20, 6'h0F, 1'b0, 1'b1, 2'h1);
    rd_chk(can_accept_pkg::OFS_STATUS, 8'h15);
    $display("test mode16 done");
  endtask
  task automatic t_std();
    wr(can_accept_pkg::OFS_CTRL, 8'h10);
    wr(can_accept_pkg::OFS_CODE_BASE, 8'hA5);
    wr(can_accept_pkg::OFS_CODE_BASE + 5'h01, 8'hA0);
    wr(can_accept_pkg::OFS_MASK_BASE + 5'h01, 8'h00);
    frame(32'hA5A00000, 6'h0D, 6'h3F, 1'b0, 1'b1, 2'h0);
    check({o_id_word[31:19], o_ext_frame}, {13'h14B4, 1'b0});
    $display("test std done");
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    i_srst <= 1'b0;
    t_reset();
    t_ext_stuff();
    t_mask();
    t_mode16();
    t_std();
    give_verdict();
  end
endmodule
